// ==== pkg/dds_ctrl_pkg.sv ====
// Purpose: Shared constants for the synthesizer control block and its ramp keying unit.
// Assumes: Registers are written into holding buffers by register index and made live by a transfer.
// Notes: Addresses are register indices on the block's write/read port.
`default_nettype none

package dds_ctrl_pkg;

  // Register indices on the configuration port.
  localparam logic [4:0] ADDR_CONTROL_ONE = 5'h00;
  localparam logic [4:0] ADDR_CONTROL_TWO = 5'h01;
  localparam logic [4:0] ADDR_AMP_SCALE = 5'h02;
  localparam logic [4:0] ADDR_RAMP_RATE = 5'h03;
  localparam logic [4:0] ADDR_FREQ_WORD = 5'h04;
  localparam logic [4:0] ADDR_PHASE_OFFSET = 5'h05;

  // Register widths.
  localparam int CONTROL_ONE_W = 32;
  localparam int CONTROL_TWO_W = 24;
  localparam int AMP_SCALE_W = 16;
  localparam int RAMP_RATE_W = 8;
  localparam int FREQ_WORD_W = 32;
  localparam int PHASE_OFFSET_W = 14;
  localparam int SCALE_W = 14;

  // Field positions in control register one.
  localparam int C1_LOAD_TIMER = 26;
  localparam int C1_KEY_ENABLE = 25;
  localparam int C1_KEY_INTERNAL = 24;
  localparam int C1_AUTO_SYNC = 23;
  localparam int C1_SOFT_SYNC = 22;
  localparam int C1_AUTO_CLEAR = 13;
  localparam int C1_CONT_CLEAR = 10;
  localparam int C1_SYNC_OUT_OFF = 1;

  // Field positions in control register two.
  localparam int C2_HS_SYNC = 11;
  localparam int C2_HW_SYNC = 10;

  // Field positions in the amplitude scale factor register.
  localparam int ASF_STEP_LO = 14;
  localparam int ASF_STEP_HI = 15;

  // Reset values.
  localparam logic [31:0] CONTROL_ONE_RESET = 32'h0000_0000;
  localparam logic [23:0] CONTROL_TWO_RESET = 24'h00_0000;
  localparam logic [15:0] AMP_SCALE_RESET = 16'h0000;
  localparam logic [7:0] RAMP_RATE_RESET = 8'h00;
  localparam logic [31:0] FREQ_WORD_RESET = 32'h0000_0000;
  localparam logic [13:0] PHASE_OFFSET_RESET = 14'h0000;

  // Timing: the sync clock is the system clock divided by four.
  localparam int SYNC_DIV = 4;
  localparam logic [13:0] FULL_SCALE = 14'h3fff;

  // Step size of the ramp scale counter, 1, 2, 4 or 8.
  function automatic logic [13:0] step_size(input logic [1:0] code);
    step_size = 14'h0001 << code;
  endfunction

endpackage

`default_nettype wire

// ==== pkg/osk_if.sv ====
// Purpose: Carries keying controls from the control block to the ramp unit and the ramp scale back.
// Assumes: One clock domain, the system clock.
// Notes: The control block drives everything except ramp_scale.
`timescale 1ns/100ps
`default_nettype none

interface osk_if;
  logic auto_mode;
  logic key_level;
  logic [1:0] step_code;
  logic [13:0] scale_limit;
  logic [7:0] ramp_rate;
  logic update_load;
  logic sync_tick;
  logic [13:0] ramp_scale;

  modport ctrl (output auto_mode, key_level, step_code, scale_limit, ramp_rate, update_load, sync_tick,
    input ramp_scale);
  modport ramp (input auto_mode, key_level, step_code, scale_limit, ramp_rate, update_load, sync_tick,
    output ramp_scale);
endinterface

`default_nettype wire

// ==== design/osk_ramp.sv ====
// Purpose: Ramp rate timer and 14-bit scale counter for automatic keying.
// Assumes: sync_tick is a one-cycle pulse at each sync clock rising edge.
// Notes: The timer counts sync clock periods; a rate of zero behaves as one.
`timescale 1ns/100ps
`default_nettype none

module osk_ramp
(
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Keying controls and ramp scale
  osk_if.ramp k
);

  logic [7:0] timer;
  logic key_prev;
  logic auto_prev;
  logic reload;
  logic expire;
  logic [14:0] up_sum;
  logic [13:0] step;

  // A pin change, entry into auto mode or a transfer with load-timer forces a reload.
  always_comb
  begin
    step = dds_ctrl_pkg::step_size(k.step_code);
    expire = k.sync_tick && (timer <= 8'h01);
    reload = (k.key_level != key_prev)
      || (k.auto_mode && !auto_prev)
      || k.update_load
      || expire;
    up_sum = {1'b0, k.ramp_scale} + {1'b0, step};
  end

  // Edge history of the keying pin and of the mode.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      key_prev <= 1'b0;
      auto_prev <= 1'b0;
    end
    else if (ce)
    begin
      key_prev <= k.key_level;
      auto_prev <= k.auto_mode;
    end
  end

  // Loadable down counter pacing the scale counter.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      timer <= 8'h00;
    else if (ce)
    begin
      if (reload)
        timer <= k.ramp_rate;
      else if (k.sync_tick)
        timer <= timer - 8'h01;
    end
  end

  // Scale counter saturates at zero and at the programmed limit, never wrapping.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      k.ramp_scale <= 14'h0000;
    else if (ce)
    begin
      if (!k.auto_mode)
        k.ramp_scale <= 14'h0000;
      else if (k.ramp_scale > k.scale_limit)
        k.ramp_scale <= k.scale_limit;
      else if (expire && k.key_level)
        k.ramp_scale <= (up_sum > {1'b0, k.scale_limit}) ? k.scale_limit : up_sum[13:0];
      else if (expire)
        k.ramp_scale <= (k.ramp_scale < step) ? 14'h0000 : k.ramp_scale - step;
    end
  end

endmodule // osk_ramp

`default_nettype wire

// ==== design/dds_phase_amplitude_sync_control.sv ====
// Purpose: Control logic of a synthesizer core: phase, keyed amplitude and sync clock alignment.
// Assumes: All inputs are synchronous to core_clk; the serial front end writes the holding buffers.
// Notes: The sync clock is core_clk divided by four; transfers land one sync period after detection.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Add the 14-bit phase offset, scaled to the accumulator top, to accumulator output.
// - Single-tone: feed the live tuning word; it changes only after write plus transfer.
// - Continuous clear bit holds the accumulator at zero; release resumes accumulation.
// - Auto-clear bit set: clear the accumulator for one cycle at every transfer.
// - Scaling applies only when keying enable is set; that bit resets clear.
// - Keying enabled: internal bit picks automatic ramp, else register keying.
// - Automatic keying: scale from 14-bit counter, up when pin high, down when low.
// - Scale is unsigned: zero gives zero, all ones gives times 16,383/16,384.
// - Step size field 00, 01, 10, 11 gives steps of 1, 2, 4, 8.
// - Ramped scale never exceeds the programmed amplitude scale factor; after a transfer lowers it, the scale stays above it for one cycle.
// - Ramp rate down counter paces the scale counter, reloading at count one.
// - A keying pin change reloads the ramp rate timer at once.
// - Load-timer bit set: every transfer also reloads the ramp rate timer.
// - Entering automatic keying mode reloads the ramp rate timer.
// - External keying uses the register scale, changed only through a transfer.
// - Auto sync bit: keep advancing the sync clock until aligned with alignment input.
// - Writing software sync bit advances sync edge one system cycle; bit self-clears.
// - Hardware sync bit: each alignment input rising edge advances sync edge one cycle.
// - Host writes go to holding buffers and become live only on a transfer strobe.
// - External keying ignores the step bits and uses the low 14 scale bits.
module dds_phase_amplitude_sync_control
#(
  parameter int ACC_W = 32
)
(
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Holding-buffer write and live-register read port
  input wire logic cfg_wr,
  input wire logic [4:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  // Device pins
  input wire logic io_update,
  input wire logic ramp_keying_input,
  input wire logic sync_in,
  output logic sync_clk_out,
  // Datapath
  input wire logic [13:0] core_sample,
  output logic [ACC_W-1:0] phase_out,
  output logic [13:0] scaled_sample,
  output logic [13:0] scale_factor
);

  // Refuse widths the offset alignment or the 32-bit tuning word cannot serve.
  generate
    if (ACC_W < dds_ctrl_pkg::PHASE_OFFSET_W || ACC_W > dds_ctrl_pkg::FREQ_WORD_W)
    begin : g_bad_width
      $error("ACC_W must lie between 14 and 32");
    end
  endgenerate

  typedef enum logic [1:0]
  {
    UPD_IDLE = 2'b01,
    UPD_PENDING = 2'b10
  } update_state_t;

  update_state_t upd_state;
  update_state_t next_upd_state;

  // Holding buffers.
  logic [31:0] buf_control_one;
  logic [23:0] buf_control_two;
  logic [15:0] buf_amp_scale;
  logic [7:0] buf_ramp_rate;
  logic [31:0] buf_freq_word;
  logic [13:0] buf_phase_offset;

  // Live registers.
  logic [31:0] control_register_one;
  logic [23:0] control_register_two;
  logic [15:0] amplitude_scale_factor;
  logic [7:0] amplitude_ramp_rate;
  logic [31:0] frequency_tuning_word;
  logic [13:0] phase_offset_value;

  logic [1:0] sync_phase;
  logic [2:0] sync_sum;
  logic sync_rise;
  logic sync_in_prev;
  logic sync_in_edge;
  logic transfer;
  logic soft_advance;
  logic advance;
  logic [ACC_W-1:0] accum;
  logic key_enable;
  logic auto_mode;
  logic [13:0] next_scale;
  logic [27:0] product;

  osk_if k ();

  osk_ramp u_ramp
  (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .k(k)
  );

  // Sync clock divider; an advance skips one count so the next rising edge comes a cycle early.
  always_comb
  begin
    sync_in_edge = sync_in && !sync_in_prev;
    soft_advance = transfer && buf_control_one[dds_ctrl_pkg::C1_SOFT_SYNC];
    advance = soft_advance
      || (control_register_two[dds_ctrl_pkg::C2_HW_SYNC] && sync_in_edge)
      || (control_register_one[dds_ctrl_pkg::C1_AUTO_SYNC] && sync_in_edge && sync_phase != 2'h0);
    sync_sum = {1'b0, sync_phase} + (advance ? 3'h2 : 3'h1);
    sync_rise = sync_sum[2];
  end

  // Divider state and alignment input history.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sync_phase <= 2'h0;
      sync_in_prev <= 1'b0;
      sync_clk_out <= 1'b0;
    end
    else if (ce)
    begin
      sync_phase <= sync_sum[1:0];
      sync_in_prev <= sync_in;
      // The pin can be silenced while the internal divider keeps running.
      sync_clk_out <= (sync_sum[1:0] < 2'h2) && !control_register_one[dds_ctrl_pkg::C1_SYNC_OUT_OFF];
    end
  end

  // The strobe is sampled on a sync rising edge and acted on one sync period later.
  always_comb
  begin
    next_upd_state = upd_state;
    transfer = 1'b0;
    case (upd_state)
      UPD_IDLE:
      begin
        if (sync_rise && io_update)
          next_upd_state = UPD_PENDING;
      end
      UPD_PENDING:
      begin
        if (sync_rise)
        begin
          transfer = 1'b1;
          next_upd_state = io_update ? UPD_PENDING : UPD_IDLE;
        end
      end
      default:
      begin
        next_upd_state = UPD_IDLE;
      end
    endcase
  end

  // Transfer state register.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      upd_state <= UPD_IDLE;
    else if (ce)
      upd_state <= next_upd_state;
  end

  // Host writes land in the buffers; a fresh write of the soft sync bit wins over its self-clear.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      buf_control_one <= dds_ctrl_pkg::CONTROL_ONE_RESET;
      buf_control_two <= dds_ctrl_pkg::CONTROL_TWO_RESET;
      buf_amp_scale <= dds_ctrl_pkg::AMP_SCALE_RESET;
      buf_ramp_rate <= dds_ctrl_pkg::RAMP_RATE_RESET;
      buf_freq_word <= dds_ctrl_pkg::FREQ_WORD_RESET;
      buf_phase_offset <= dds_ctrl_pkg::PHASE_OFFSET_RESET;
    end
    else if (ce)
    begin
      if (soft_advance)
        buf_control_one[dds_ctrl_pkg::C1_SOFT_SYNC] <= 1'b0;
      if (cfg_wr)
      begin
        case (cfg_addr)
          dds_ctrl_pkg::ADDR_CONTROL_ONE: buf_control_one <= cfg_wdata;
          dds_ctrl_pkg::ADDR_CONTROL_TWO: buf_control_two <= cfg_wdata[23:0];
          dds_ctrl_pkg::ADDR_AMP_SCALE: buf_amp_scale <= cfg_wdata[15:0];
          dds_ctrl_pkg::ADDR_RAMP_RATE: buf_ramp_rate <= cfg_wdata[7:0];
          dds_ctrl_pkg::ADDR_FREQ_WORD: buf_freq_word <= cfg_wdata;
          dds_ctrl_pkg::ADDR_PHASE_OFFSET: buf_phase_offset <= cfg_wdata[13:0];
          default:
          begin
          end
        endcase
      end
    end
  end

  // Live registers change only on a transfer; the soft sync bit is never kept live.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      control_register_one <= dds_ctrl_pkg::CONTROL_ONE_RESET;
      control_register_two <= dds_ctrl_pkg::CONTROL_TWO_RESET;
      amplitude_scale_factor <= dds_ctrl_pkg::AMP_SCALE_RESET;
      amplitude_ramp_rate <= dds_ctrl_pkg::RAMP_RATE_RESET;
      frequency_tuning_word <= dds_ctrl_pkg::FREQ_WORD_RESET;
      phase_offset_value <= dds_ctrl_pkg::PHASE_OFFSET_RESET;
    end
    else if (ce && transfer)
    begin
      control_register_one <= buf_control_one & ~(32'h1 << dds_ctrl_pkg::C1_SOFT_SYNC);
      control_register_two <= buf_control_two;
      amplitude_scale_factor <= buf_amp_scale;
      amplitude_ramp_rate <= buf_ramp_rate;
      frequency_tuning_word <= buf_freq_word;
      phase_offset_value <= buf_phase_offset;
    end
  end

  // Readback shows the live registers, not the buffers.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cfg_rdata <= 32'h0000_0000;
    else if (ce)
    begin
      case (cfg_addr)
        dds_ctrl_pkg::ADDR_CONTROL_ONE: cfg_rdata <= control_register_one;
        dds_ctrl_pkg::ADDR_CONTROL_TWO: cfg_rdata <= {8'h00, control_register_two};
        dds_ctrl_pkg::ADDR_AMP_SCALE: cfg_rdata <= {16'h0000, amplitude_scale_factor};
        dds_ctrl_pkg::ADDR_RAMP_RATE: cfg_rdata <= {24'h00_0000, amplitude_ramp_rate};
        dds_ctrl_pkg::ADDR_FREQ_WORD: cfg_rdata <= frequency_tuning_word;
        dds_ctrl_pkg::ADDR_PHASE_OFFSET: cfg_rdata <= {18'h0_0000, phase_offset_value};
        default: cfg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // Phase accumulator; the auto-clear looks at the value being transferred so it acts on that strobe.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      accum <= '0;
    else if (ce)
    begin
      if (control_register_one[dds_ctrl_pkg::C1_CONT_CLEAR])
        accum <= '0;
      else if (transfer && buf_control_one[dds_ctrl_pkg::C1_AUTO_CLEAR])
        accum <= '0;
      else
        accum <= accum + frequency_tuning_word[ACC_W-1:0];
    end
  end

  // Offset is aligned to the top 14 bits, so one count is 360 degrees over 2 to the 14th.
  always_ff @(posedge core_clk)
  begin
    if (rst)
      phase_out <= '0;
    else if (ce)
      phase_out <= accum + (ACC_W'(phase_offset_value) << (ACC_W - dds_ctrl_pkg::PHASE_OFFSET_W));
  end

  // Keying controls toward the ramp unit.
  always_comb
  begin
    key_enable = control_register_one[dds_ctrl_pkg::C1_KEY_ENABLE];
    auto_mode = key_enable && control_register_one[dds_ctrl_pkg::C1_KEY_INTERNAL];
    k.auto_mode = auto_mode;
    k.key_level = ramp_keying_input;
    k.step_code = amplitude_scale_factor[dds_ctrl_pkg::ASF_STEP_HI:dds_ctrl_pkg::ASF_STEP_LO];
    k.scale_limit = amplitude_scale_factor[13:0];
    k.ramp_rate = amplitude_ramp_rate;
    k.update_load = transfer && buf_control_one[dds_ctrl_pkg::C1_LOAD_TIMER];
    k.sync_tick = sync_rise;
  end

  // Scale source: bypass, automatic ramp, or the register's low bits alone.
  always_comb
  begin
    if (!key_enable)
      next_scale = dds_ctrl_pkg::FULL_SCALE;
    else if (auto_mode)
      next_scale = k.ramp_scale;
    else
      next_scale = amplitude_scale_factor[13:0];
    product = core_sample * next_scale;
  end

  // Scaled output; in bypass the sample passes untouched rather than losing one count.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      scale_factor <= 14'h0000;
      scaled_sample <= 14'h0000;
    end
    else if (ce)
    begin
      scale_factor <= next_scale;
      scaled_sample <= key_enable ? product[27:14] : core_sample;
    end
  end

endmodule // dds_phase_amplitude_sync_control

`default_nettype wire

// ==== dv/sync_master_model.sv ====
// Purpose: Master synthesizer as seen on the alignment input: a sync clock of core_clk over four.
// Assumes: Shares core_clk with the block.
// Notes: The output is held low while the master is stopped.
`timescale 1ns/100ps
`default_nettype none

module sync_master_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control and sync clock out
  input wire logic run,
  output logic sync_in
);
  logic [1:0] div;

  // The divider restarts from phase zero at each start, so a restart shifts the master's phase.
  always_ff @(posedge core_clk)
  begin
    if (rst || !run)
    begin
      div <= 2'h0;
      sync_in <= 1'b0;
    end
    else
    begin
      div <= div + 2'h1;
      sync_in <= (div < 2'h2);
    end
  end
endmodule // sync_master_model

`default_nettype wire

// ==== dv/dds_ctrl_monitor.sv ====
// Purpose: Port-level assertions for the synthesizer control block.
// Assumes: ce stays high; sync_in only moves while a sync mode is exercised.
// Notes: A quiet counter masks cycles near transfer strobes and alignment levels.
`timescale 1ns/100ps
`default_nettype none

module dds_ctrl_monitor
#(
  parameter int ACC_W = 32
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Watched inputs
  input wire logic io_update,
  input wire logic sync_in,
  input wire logic [4:0] cfg_addr,
  input wire logic [13:0] core_sample,
  // Watched outputs
  input wire logic [31:0] cfg_rdata,
  input wire logic sync_clk_out,
  input wire logic [ACC_W-1:0] phase_out,
  input wire logic [13:0] scaled_sample,
  input wire logic [13:0] scale_factor
);
  logic [3:0] quiet;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Cycles since a strobe or alignment level; it saturates so it cannot wrap back into range.
  always_ff @(posedge core_clk)
  begin
    if (rst || io_update || sync_in || !ce)
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
  end

  // Unmapped indices read zero; live registers and the phase step only move through a transfer.
  a_unmapped_reads_zero: assert property (cfg_addr > 5'h05 |=> cfg_rdata == 32'h0)
    else $error("unmapped index read back nonzero");
  a_readback_held: assert property (quiet > 4'hb && $stable(cfg_addr) |=> $stable(cfg_rdata))
    else $error("readback changed without a transfer");
  a_phase_step_steady: assert property (quiet > 4'hb |->
    ACC_W'(phase_out - $past(phase_out)) == ACC_W'($past(phase_out) - $past(phase_out, 2)))
    else $error("phase step changed without a transfer");
  // The sync clock is high two and low two while no advance source is active.
  a_sync_period_four: assert property ($rose(sync_clk_out) && quiet == 4'hf |=>
    sync_clk_out ##1 !sync_clk_out [*2] ##1 sync_clk_out)
    else $error("sync clock period not four cycles");
  // Keying is off after reset, and scaling is unsigned and never amplifies.
  a_reset_bypass: assert property ($fell(rst) |-> ##[1:4] scale_factor == 14'h3fff)
    else $error("scale not full after reset");
  a_zero_scale_mutes: assert property (!$past(rst) && scale_factor == 14'h0 &&
    $past(scale_factor) == 14'h0 |-> scaled_sample == 14'h0)
    else $error("zero scale did not mute the sample");
  a_bypass_unscaled: assert property (!$past(rst) && scale_factor == 14'h3fff &&
    $past(scale_factor) == 14'h3fff |-> scaled_sample >= $past(core_sample) - 14'h1)
    else $error("full scale output lost amplitude");
  a_scaled_not_above: assert property (!$past(rst) |-> scaled_sample <= $past(core_sample))
    else $error("scaled sample above core sample");

  c_soft_advance: cover property ($rose(sync_clk_out) ##3 $rose(sync_clk_out));
  c_ramp_rises: cover property (scale_factor == 14'h0 ##1 scale_factor == 14'h1);
  c_transfer: cover property (io_update ##4 !io_update);
endmodule // dds_ctrl_monitor

bind dds_phase_amplitude_sync_control dds_ctrl_monitor #(.ACC_W(ACC_W)) u_dds_ctrl_monitor (.core_clk(core_clk),
  .rst(rst), .ce(ce), .io_update(io_update), .sync_in(sync_in), .cfg_addr(cfg_addr), .core_sample(core_sample),
  .cfg_rdata(cfg_rdata), .sync_clk_out(sync_clk_out), .phase_out(phase_out), .scaled_sample(scaled_sample),
  .scale_factor(scale_factor));

`default_nettype wire

// ==== dv/dds_phase_amplitude_sync_control_tb_top.sv ====
// Purpose: Directed bench for the synthesizer control block.
// Assumes: ce held high except for one five-cycle freeze check; core_sample held at one value.
// Notes: Inputs move 2 ns after the rising edge of core_clk.
`timescale 1ns/100ps
`default_nettype none

module dds_phase_amplitude_sync_control_tb_top;
  localparam logic [4:0] C1 = dds_ctrl_pkg::ADDR_CONTROL_ONE;
  localparam logic [4:0] C2 = dds_ctrl_pkg::ADDR_CONTROL_TWO;
  localparam logic [4:0] AMP = dds_ctrl_pkg::ADDR_AMP_SCALE;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cfg_wr = 1'b0;
  logic [4:0] cfg_addr = 5'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic io_update = 1'b0;
  logic ramp_keying_input = 1'b0;
  logic run = 1'b0;
  logic [13:0] core_sample = 14'h3000;
  logic sync_in, sync_clk_out;
  logic [31:0] cfg_rdata, phase_out, p1;
  logic [13:0] scaled_sample, scale_factor, v;
  logic [15:0] asf_v [3] = '{16'hc123, 16'h0000, 16'h3fff};
  int error_cnt = 0;
  int n_tests = 0;
  int k, c, g;

  dds_phase_amplitude_sync_control #(.ACC_W(32)) u_dds_phase_amplitude_sync_control (.core_clk(core_clk),
    .rst(rst), .ce(ce), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .io_update(io_update), .ramp_keying_input(ramp_keying_input), .sync_in(sync_in),
    .sync_clk_out(sync_clk_out), .core_sample(core_sample), .phase_out(phase_out),
    .scaled_sample(scaled_sample), .scale_factor(scale_factor));
  sync_master_model u_sync_master_model (.core_clk(core_clk), .rst(rst), .run(run), .sync_in(sync_in));

  // 25 MHz system clock.
  always #20 core_clk = ~core_clk;

  // Bus helpers; a transfer holds the strobe across exactly one sync rise.
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    tick(1);
    cfg_wr = 1'b0;
    // One idle edge keeps a following write from raising the strobe in the same time step.
    tick(1);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    cfg_addr = a;
    tick(1);
    check("cfg_rdata", e, cfg_rdata);
  endtask
  task automatic upd(input int tail);
    io_update = 1'b1;
    tick(4);
    io_update = 1'b0;
    tick(tail);
  endtask
  // Shortest rise-to-rise gap of the sync clock seen in n cycles.
  task automatic min_gap(input int n, output int m);
    int last;
    logic prev;
    last = -99;
    m = 99;
    prev = sync_clk_out;
    for (int i = 0; i < n; i++)
    begin
      tick(1);
      if (sync_clk_out && !prev && i - last < m)
        m = i - last;
      if (sync_clk_out && !prev)
        last = i;
      prev = sync_clk_out;
    end
  endtask
  task automatic wait_chg(output int n);
    logic [13:0] s;
    s = scale_factor;
    n = 0;
    while (scale_factor === s && n < 400)
    begin
      tick(1);
      n++;
    end
  endtask
  task automatic settle(input logic [13:0] t);
    for (int i = 0; i < 4000 && scale_factor !== t; i++)
      tick(1);
    check("scale_factor", {18'h0, t}, {18'h0, scale_factor});
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog: the sequence needs about 10000 cycles.
  initial
  begin
    #1600000;
    error_cnt++;
    $display("[ERR] watchdog expected finish seen timeout");
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    tick(6);
    rst = 1'b0;
    for (k = 0; k < 6; k++)
      rd(5'(k), 32'h0);
    rd(5'h1f, 32'h0);
    check("scale_factor", 32'h3fff, {18'h0, scale_factor});
    check("scaled_sample", 32'h3000, {18'h0, scaled_sample});
    // Buffered writes, phase offset and continuous clear.
    wr(dds_ctrl_pkg::ADDR_FREQ_WORD, 32'h0001_0000);
    wr(dds_ctrl_pkg::ADDR_PHASE_OFFSET, 32'h1234);
    wr(C1, 32'h0000_0400);
    rd(dds_ctrl_pkg::ADDR_FREQ_WORD, 32'h0);
    upd(6);
    rd(dds_ctrl_pkg::ADDR_FREQ_WORD, 32'h0001_0000);
    p1 = {14'h1234, 18'h0};
    check("phase_out", p1, phase_out);
    // Auto-clear on two transfers, then a transfer that clears the bit leaves the phase running.
    wr(C1, 32'h0000_2000);
    for (k = 0; k < 3; k++)
    begin
      if (k == 2)
        wr(C1, 32'h0);
      tick(100);
      upd(6);
      check("phase_cleared", 32'(k < 2), 32'(phase_out - p1 < 32'h0010_0000));
    end
    // A low clock enable freezes the running phase.
    g = phase_out;
    ce = 1'b0;
    tick(5);
    check("ce_freeze", 32'(g), phase_out);
    ce = 1'b1;
    // Software sync advances once; the bit is gone afterwards.
    min_gap(40, g);
    check("sync_gap", 32'd4, 32'(g));
    wr(C1, 32'h0040_0000);
    for (k = 0; k < 2; k++)
    begin
      fork
        min_gap(20, g);
        upd(0);
      join
      check("soft_gap", k ? 32'd4 : 32'd3, 32'(g));
    end
    rd(C1, 32'h0);
    // Hardware sync: every alignment edge advances until the bit is cleared.
    wr(C2, 32'h0000_0400);
    upd(6);
    for (k = 0; k < 3; k++)
    begin
      if (k == 2)
        wr(C2, 32'h0);
      if (k == 2)
        upd(6);
      fork
        min_gap(16, g);
        begin
          tick(4);
          run = 1'b1;
          tick(2);
          run = 1'b0;
        end
      join
      check("hw_gap", k < 2 ? 32'd3 : 32'd4, 32'(g));
    end
    // Automatic sync: realign after the master restarts two cycles off, then hold steady.
    wr(C1, 32'h0080_0000);
    wr(C2, 32'h0000_0800);
    upd(6);
    run = 1'b1;
    min_gap(40, g);
    while (sync_in)
      tick(1);
    while (!sync_in)
      tick(1);
    run = 1'b0;
    tick(1);
    run = 1'b1;
    min_gap(40, g);
    check("auto_gap", 32'd3, 32'(g));
    min_gap(40, g);
    check("auto_steady", 32'd4, 32'(g));
    wr(C1, 32'h0);
    upd(6);
    run = 1'b0;
    // Register keying: internal bit ignored while disabled, then step bits ignored.
    wr(C1, 32'h0100_0000);
    upd(6);
    check("scale_factor", 32'h3fff, {18'h0, scale_factor});
    wr(C1, 32'h0200_0000);
    foreach (asf_v[i])
    begin
      wr(AMP, {16'h0, asf_v[i]});
      check("scale_held", i ? 32'(asf_v[i - 1][13:0]) : 32'h3fff, {18'h0, scale_factor});
      upd(6);
      check("scale_factor", {18'h0, asf_v[i][13:0]}, {18'h0, scale_factor});
      check("scaled_sample", 32'h3000 * {18'h0, asf_v[i][13:0]} >> 14, {18'h0, scaled_sample});
    end
    // Automatic ramp for every step code, rate 3 sync periods, limit 0x105.
    wr(dds_ctrl_pkg::ADDR_RAMP_RATE, 32'h3);
    wr(C1, 32'h0300_0000);
    for (k = 0; k < 4; k++)
    begin
      ramp_keying_input = 1'b0;
      wr(AMP, {16'h0, 2'(k), 14'h0105});
      upd(6);
      settle(14'h0);
      ramp_keying_input = 1'b1;
      wait_chg(c);
      wait_chg(c);
      v = scale_factor;
      wait_chg(c);
      check("scale_step", 32'h1 << k, {18'h0, scale_factor - v});
      check("step_cycles", 32'd12, 32'(c));
      settle(14'h0105);
    end
    give_verdict();
  end
endmodule // dds_phase_amplitude_sync_control_tb_top

`default_nettype wire
